// file: sim/gpt_pin_partner.sv
// board-side pin model: resolves each pin from the port drive and the board level
`timescale 1ns/100ps
module gpt_pin_partner (
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] board_val,
    output logic      [7:0] pin_i
);
    // the board only drives bits the port has released, so there is never contention
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & board_val);
endmodule // gpt_pin_partner

// file: sim/gpt_port_with_debug_trace_mux_tb.sv
// self-checking bench for the trace-capable port against a behavioural reference
`timescale 1ns/100ps
`define CHK(nm, x, y) begin total_checks++; if ((y) !== (x)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, x, y); end end
module gpt_port_with_debug_trace_mux_tb;
    import gpt_pkg::*;
    logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_address, avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    gpt_level_t  debug_level;
    logic [7:0]  tdat, tctl, pin_i, pin_o, pin_oe, cdir, clat, comp_o, comp_oe, board;
    int          fail_count, total_checks, cycles, dir, func, lat, lvl, e;

    gpt_port dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .debug_level(debug_level),
        .trace_data_output(tdat), .trace_control_output(tctl), .port_pin_i(pin_i),
        .port_pin_o(pin_o), .port_pin_oe(pin_oe), .companion_direction_control(cdir),
        .companion_latch(clat), .comp_pin_o(comp_o), .comp_pin_oe(comp_oe));
    gpt_pin_partner pins (.pin_o(pin_o), .pin_oe(pin_oe), .board_val(board), .pin_i(pin_i));

    // 250 mhz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // hang guard: the run needs about 630 cycles, so this leaves wide margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one bus cycle; idle edge first so a release and a new request never share a step
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // reference source per port: 0 plain, 1 trace data, 2 trace control; lv 0..3 = 0,1,3,5
    function automatic int src(input int port, input int lv, input int fn);
        if (port == 0) return (lv == 3 || (lv == 2 && fn == 255)) ? 1 : 0;
        return (lv == 0) ? 0 : (lv == 2) ? ((fn == 255) ? 0 : 1) : 2;
    endfunction

    // reference pins: enables in bits 15:8, driven values in 7:0
    function automatic int drive(input int s, input int fn, input int dr, input int lt);
        int m;
        int t;
        m = (s != 0) ? fn : 0;
        t = (s == 1) ? int'(tdat) : int'(tctl);
        return ((m & t) | (~m & dr & lt) & 255) | (((dr | m) & 255) << 8);
    endfunction

    // main sequence
    initial begin
        void'($urandom(84014));
        rst_n          = 1'b0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_address    = 32'h00000000;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'h0;
        debug_level    = GPT_LVL0;
        tdat           = 8'h00;
        tctl           = 8'h00;
        cdir           = 8'h00;
        clat           = 8'h00;
        board          = 8'h5a;
        fail_count     = 0;
        total_checks   = 0;
        cycles         = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        `CHK("oe after reset", 8'h00, pin_oe)
        bus(1'b0, GPT_OFS_DIR, 32'h0, 4'h1, rd);
        `CHK("dir reset", 32'h0, rd)
        bus(1'b0, GPT_OFS_FUNC, 32'h0, 4'h1, rd);
        `CHK("func reset", 32'h0, rd)
        bus(1'b0, GPT_OFS_DATA, 32'h0, 4'h1, rd);
        `CHK("data as input", 32'h5a, rd)
        // refused accesses: no byte lane, unmapped place
        bus(1'b1, GPT_OFS_DIR, 32'hff, 4'h0, rd);
        bus(1'b1, GPT_OFS_FUNC, 32'hff, 4'h0, rd);
        bus(1'b0, GPT_OFS_FUNC, 32'h0, 4'h1, rd);
        `CHK("func refused", 32'h0, rd)
        bus(1'b1, GPT_UNMAPPED, 32'hff, 4'h1, rd);
        bus(1'b0, GPT_UNMAPPED, 32'h0, 4'h1, rd);
        `CHK("unmapped", 32'h0, rd)
        `CHK("oe unchanged", 8'h00, pin_oe)
        bus(1'b1, GPT_OFS_DIR, 32'hff, 4'h1, rd);
        bus(1'b0, GPT_OFS_DATA, 32'h0, 4'h1, rd);
        `CHK("latch preset", 32'hff, rd)
        `CHK("oe output", 8'hff, pin_oe)
        // random sweep over every level, with function byte all ones every third pass
        for (int i = 0; i < 48; i++) begin
            lvl  = i % 4;
            dir  = $urandom_range(255);
            lat  = $urandom_range(255);
            func = (i % 3 == 0) ? 255 : $urandom_range(255);
            debug_level <= gpt_level_t'(lvl);
            tdat        <= 8'($urandom);
            tctl        <= 8'($urandom);
            cdir        <= 8'($urandom);
            clat        <= 8'($urandom);
            board       <= 8'($urandom);
            bus(1'b1, GPT_OFS_DIR, dir, 4'h1, rd);
            bus(1'b1, GPT_OFS_FUNC, func, 4'h1, rd); // whole byte
            bus(1'b1, GPT_OFS_DATA, lat, 4'h1, rd);
            bus(1'b0, GPT_OFS_DATA, 32'h0, 4'h1, rd);
            e = drive(src(0, lvl, func), func, dir, lat);
            `CHK("pins", e[15:0], {pin_oe, pin_o & pin_oe})
            e = ((e >> 8) & e) | (~(e >> 8) & int'(board));
            `CHK("data", 32'((dir & lat) | (~dir & e & 255)), rd)
            e = drive(src(1, lvl, func), func, int'(cdir), int'(clat));
            `CHK("companion", e[15:0], {comp_oe, comp_o & comp_oe})
        end
        // reset in mid-run: registers written by the sweep must return to reset values
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        `CHK("oe after second reset", 8'h00, pin_oe)
        bus(1'b0, GPT_OFS_FUNC, 32'h0, 4'h1, rd);
        `CHK("func second reset", 32'h0, rd)
        bus(1'b1, GPT_OFS_DIR, 32'hff, 4'h1, rd);
        bus(1'b0, GPT_OFS_DATA, 32'h0, 4'h1, rd);
        `CHK("latch second preset", 32'hff, rd)
        end_of_test();
    end
endmodule // gpt_port_with_debug_trace_mux_tb

// file: verilog/gpt_level_map.sv
// debug-level to port-function mapping for both ports
`timescale 1ns/100ps
module gpt_level_map
    import gpt_pkg::*;
(
    input  wire gpt_level_t  debug_level,
    input  wire logic [7:0]  func_reg,
    output gpt_src_t         main_src,
    output gpt_src_t         comp_src
);
    wire func_full = (func_reg == GPT_FUNC_ALL);

    // ********************************
    // level table
    // ********************************
    always_comb begin
        main_src = GPT_SRC_PORT;
        comp_src = GPT_SRC_PORT;
        case (debug_level)
            GPT_LVL0: begin
                main_src = GPT_SRC_PORT;                    // see [RQ7]
                comp_src = GPT_SRC_PORT;                    // see [RQ8]
            end
            GPT_LVL1: begin
                main_src = GPT_SRC_PORT;                    // see [RQ7]
                comp_src = GPT_SRC_TCTRL;                   // see [RQ8]
            end
            GPT_LVL3: begin
                main_src = func_full ? GPT_SRC_TDATA : GPT_SRC_PORT;  // see [RQ7]
                comp_src = func_full ? GPT_SRC_PORT : GPT_SRC_TDATA;  // see [RQ8]
            end
            GPT_LVL5: begin
                main_src = GPT_SRC_TDATA;                   // see [RQ7]
                comp_src = GPT_SRC_TCTRL;                   // see [RQ8]
            end
            default: begin
                main_src = GPT_SRC_PORT;
                comp_src = GPT_SRC_PORT;
            end
        endcase
    end
endmodule // gpt_level_map

// file: verilog/gpt_pin_mux.sv
// per-pin output selection between port latch and trace signal
`timescale 1ns/100ps
module gpt_pin_mux
    import gpt_pkg::*;
#(
    parameter int WIDTH = GPT_WIDTH
) (
    input  wire gpt_src_t          src,
    input  wire logic [WIDTH-1:0]  func_bits,
    input  wire logic [WIDTH-1:0]  dir_bits,
    input  wire logic [WIDTH-1:0]  latch,
    input  wire logic [WIDTH-1:0]  trace_data,
    input  wire logic [WIDTH-1:0]  trace_ctrl,
    output logic      [WIDTH-1:0]  pin_o,
    output logic      [WIDTH-1:0]  pin_oe
);
    // trace needs both the level and the pin's own function bit
    wire [WIDTH-1:0] trace_sel = (src != GPT_SRC_PORT) ? func_bits : '0;   // see [RQ5]
    wire [WIDTH-1:0] trace_val = (src == GPT_SRC_TCTRL) ? trace_ctrl : trace_data;

    assign pin_o  = (trace_sel & trace_val) | (~trace_sel & latch);  // see [RQ4]
    assign pin_oe = trace_sel | dir_bits;                            // see [RQ1]
endmodule // gpt_pin_mux

// file: verilog/gpt_pkg.sv
// package: register map, reset values and debug levels of the trace-capable port
package gpt_pkg;
    localparam int          GPT_WIDTH       = 8;
    localparam int          GPT_AW          = 32;
    // byte addresses of the three registers (one aligned word each)
    localparam logic [31:0] GPT_OFS_DATA    = 32'hfffff0d0;
    localparam logic [31:0] GPT_OFS_DIR     = 32'hfffff0d4;
    localparam logic [31:0] GPT_OFS_FUNC    = 32'hfffff0d8;
    // reset values
    localparam logic [7:0]  GPT_RST_DIR     = 8'h00;
    localparam logic [7:0]  GPT_RST_FUNC    = 8'h00;
    localparam logic [7:0]  GPT_RST_LATCH   = 8'hff;
    localparam logic [7:0]  GPT_FUNC_ALL    = 8'hff;
    localparam logic [3:0]  GPT_WHOLE_BYTE  = 4'h1;
    localparam logic [31:0] GPT_UNMAPPED    = 32'h00000000;
    // active debug level as presented by the debug unit
    typedef enum logic [2:0] {
        GPT_LVL0,
        GPT_LVL1,
        GPT_LVL3,
        GPT_LVL5
    } gpt_level_t;
    // what one 8-bit port carries
    typedef enum logic [1:0] {
        GPT_SRC_PORT,
        GPT_SRC_TDATA,
        GPT_SRC_TCTRL
    } gpt_src_t;
endpackage

// file: verilog/gpt_port.sv
// trace-capable 8-bit general-purpose port with avalon-mm registers
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps

// Contract
// [RQ1] Each of the eight pins is an input when its direction bit is 0 and an output when 1.
// [RQ2] Reset clears the direction and function registers so all pins start as inputs.
// [RQ3] Reset presets the output latch to all ones while pins stay inputs.
// [RQ4] Each pin may carry a trace signal instead of port data when its function bit is 1.
// [RQ5] A pin drives trace only when the debug level and its function bit both call for it.
// [RQ6] Software writes the function register as a whole byte only.
// [RQ7] This port is plain at levels 0 and 1, data at level 3 only if function is ff, data at 5.
// [RQ8] Companion: plain at 0, control at 1, at 3 plain if function is ff else data, control at 5.
// [RQ9] The debug tool sets up the port registers whenever trace output is needed.
// [RQ10] Software should not use the port as plain i/o while a probe uses it for trace.
// [RQ11] Reading data returns pin levels for inputs and latch values for outputs.
module gpt_port
    import gpt_pkg::*;
#(
    parameter int WIDTH = GPT_WIDTH
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // avalon-mm slave
    input  wire logic [GPT_AW-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // debug unit
    input  wire gpt_level_t        debug_level,
    input  wire logic [WIDTH-1:0]  trace_data_output,
    input  wire logic [WIDTH-1:0]  trace_control_output,
    // this port's pins
    input  wire logic [WIDTH-1:0]  port_pin_i,
    output logic      [WIDTH-1:0]  port_pin_o,
    output logic      [WIDTH-1:0]  port_pin_oe,
    // companion port trace drive (its port logic lives elsewhere)
    input  wire logic [WIDTH-1:0]  companion_direction_control,
    input  wire logic [WIDTH-1:0]  companion_latch,
    output logic      [WIDTH-1:0]  comp_pin_o,
    output logic      [WIDTH-1:0]  comp_pin_oe
);
    // ********************************
    // registers
    // ********************************
    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] latch_next;
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] dir_next;
    logic [WIDTH-1:0] func_reg;
    logic [WIDTH-1:0] func_next;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;
    logic             ack_reg;
    gpt_src_t         main_src;
    gpt_src_t         comp_src;

    // ********************************
    // bus decode
    // ********************************
    // one wait cycle: request is answered on the edge after ack_reg rises
    wire req      = avs_read | avs_write;
    wire take     = req & ack_reg;
    wire hit_data = (avs_address == GPT_OFS_DATA);
    wire hit_dir  = (avs_address == GPT_OFS_DIR);
    wire hit_func = (avs_address == GPT_OFS_FUNC);
    wire lane0    = avs_byteenable[0];
    wire wr_data  = take & avs_write & hit_data & lane0;
    wire wr_dir   = take & avs_write & hit_dir & lane0;
    // partial byte never occurs on an 8-bit field; be[0] carries the byte
    wire wr_func  = take & avs_write & hit_func &
                    (avs_byteenable[0] == GPT_WHOLE_BYTE[0]);    // see [RQ6]
    wire [WIDTH-1:0] data_view = (dir_reg & latch_reg) | (~dir_reg & port_pin_i);    // see [RQ11]

    assign latch_next = wr_data ? avs_writedata[WIDTH-1:0] : latch_reg;
    assign dir_next   = wr_dir  ? avs_writedata[WIDTH-1:0] : dir_reg;      // see [RQ1]
    assign func_next  = wr_func ? avs_writedata[WIDTH-1:0] : func_reg;     // see [RQ4]
    assign rdata_next = hit_data ? {{(32-WIDTH){1'b0}}, data_view} :
                        hit_dir  ? {{(32-WIDTH){1'b0}}, dir_reg} :
                        hit_func ? {{(32-WIDTH){1'b0}}, func_reg} : GPT_UNMAPPED;
    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    // register file; reset values give an all-input port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= GPT_RST_LATCH;     // see [RQ3]
            dir_reg   <= GPT_RST_DIR;       // see [RQ2]
            func_reg  <= GPT_RST_FUNC;      // see [RQ2]
        end else begin
            latch_reg <= latch_next;
            dir_reg   <= dir_next;
            func_reg  <= func_next;
        end
    end

    // handshake: ack toggles low after each accepted request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= GPT_UNMAPPED;
        end else begin
            ack_reg   <= req & ~ack_reg;
            rdata_reg <= (req & ~ack_reg & avs_read) ? rdata_next : rdata_reg;
        end
    end

    // ********************************
    // pin muxing
    // ********************************
    gpt_level_map u_map (
        .debug_level (debug_level),
        .func_reg    (func_reg),
        .main_src    (main_src),
        .comp_src    (comp_src)
    );

    gpt_pin_mux #(.WIDTH(WIDTH)) u_main (
        .src        (main_src),
        .func_bits  (func_reg),
        .dir_bits   (dir_reg),
        .latch      (latch_reg),
        .trace_data (trace_data_output),
        .trace_ctrl (trace_control_output),
        .pin_o      (port_pin_o),
        .pin_oe     (port_pin_oe)
    );

    // companion follows the same function bits, per the shared table
    gpt_pin_mux #(.WIDTH(WIDTH)) u_comp (
        .src        (comp_src),
        .func_bits  (func_reg),
        .dir_bits   (companion_direction_control),
        .latch      (companion_latch),
        .trace_data (trace_data_output),
        .trace_ctrl (trace_control_output),
        .pin_o      (comp_pin_o),
        .pin_oe     (comp_pin_oe)
    );

    // ********************************
    // checks
    // ********************************
    chk_reset_dir_func: assert property (@(posedge core_clk)   // see [RQ2]
        $rose(rst_n) |-> (dir_reg == GPT_RST_DIR) && (func_reg == GPT_RST_FUNC))
        else $error("dir or func not cleared at reset");
    chk_reset_latch_ones: assert property (@(posedge core_clk)   // see [RQ3]
        $rose(rst_n) |-> (latch_reg == GPT_RST_LATCH))
        else $error("latch not preset to ones");
    chk_input_no_drive: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ1]
        (debug_level == GPT_LVL0) |-> (port_pin_oe == dir_reg))
        else $error("output enable differs from direction");
    chk_level1_port: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ7]
        (debug_level == GPT_LVL1) |-> (port_pin_o == latch_reg))
        else $error("port carries trace at level 1");
    chk_level5_trace: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ7]
        (debug_level == GPT_LVL5) && (func_reg == GPT_FUNC_ALL)
        |-> (port_pin_o == trace_data_output) && (&port_pin_oe))
        else $error("level 5 does not drive trace data");
    chk_comp_level3: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ8]
        (debug_level == GPT_LVL3) && (func_reg == GPT_FUNC_ALL)
        |-> (comp_pin_o == companion_latch))
        else $error("companion not plain at split level");
    chk_comp_level1: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ8]
        (debug_level == GPT_LVL1) && (func_reg == GPT_FUNC_ALL)
        |-> (comp_pin_o == trace_control_output))
        else $error("companion lacks trace control at level 1");
    chk_trace_needs_bit: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ5]
        (func_reg == GPT_RST_FUNC)
        |-> (port_pin_o == latch_reg) && (comp_pin_o == companion_latch))
        else $error("trace driven without function bit");
    chk_write_func: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ4]
        wr_func |=> (func_reg == $past(avs_writedata[WIDTH-1:0])))
        else $error("function write lost");
    chk_read_view: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ11]
        (avs_read && !ack_reg && hit_data) |=> (avs_readdata[WIDTH-1:0] == $past(data_view)))
        else $error("data read does not merge pins and latch");

    // ********************************
    // bus handshake checks
    // ********************************
    // first step of a transfer: a fresh request is held off
    sequence gpt_seq_wait;
        avs_waitrequest && !ack_reg;
    endsequence

    // second step: the held request is answered in the next cycle
    sequence gpt_seq_answer;
        !avs_waitrequest && ack_reg;
    endsequence

    // a master that keeps its request never waits more than one cycle
    chk_one_wait_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ11]
        (req && !ack_reg) |-> gpt_seq_wait ##1 gpt_seq_answer)
        else $error("request not answered after one wait cycle");

    // ack must not stand two cycles, or a held request would be taken twice
    chk_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ11]
        ack_reg |=> !ack_reg)
        else $error("acknowledge stood for two cycles");

    // accepted direction write lands on the next edge
    chk_write_dir: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ1]
        wr_dir |=> (dir_reg == $past(avs_writedata[WIDTH-1:0])))
        else $error("direction write lost");

    // accepted data write lands in the output latch
    chk_write_latch: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ11]
        wr_data |=> (latch_reg == $past(avs_writedata[WIDTH-1:0])))
        else $error("data latch write lost");

    // direction only moves on an accepted write
    chk_dir_stable: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ1]
        (!wr_dir) |=> $stable(dir_reg))
        else $error("direction changed without a write");

    // function byte only moves on a whole-byte write
    chk_func_stable: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ6]
        (!wr_func) |=> $stable(func_reg))
        else $error("function changed without a write");

    // latch keeps its preset until software writes it
    chk_latch_stable: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ3]
        (!wr_data) |=> $stable(latch_reg))
        else $error("latch changed without a write");

    // a write with no byte lane leaves every register alone
    chk_no_lane_write: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ6]
        (take && avs_write && !lane0)
        |=> $stable(dir_reg) && $stable(func_reg) && $stable(latch_reg))
        else $error("write without a byte lane changed a register");

    // direction reads back as written
    chk_read_dir: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ1]
        (avs_read && !ack_reg && hit_dir) |=> (avs_readdata[WIDTH-1:0] == $past(dir_reg)))
        else $error("direction read back wrong");

    // function byte reads back as written
    chk_read_func: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ4]
        (avs_read && !ack_reg && hit_func) |=> (avs_readdata[WIDTH-1:0] == $past(func_reg)))
        else $error("function read back wrong");

    // only the low byte carries data; the rest of the word reads zero
    chk_read_upper: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ11]
        ack_reg |-> (avs_readdata[31:WIDTH] == '0))
        else $error("upper read bits not zero");

    // read data is cleared with the registers
    chk_reset_rdata: assert property (@(posedge core_clk)   // see [RQ2]
        $rose(rst_n) |-> (avs_readdata == GPT_UNMAPPED))
        else $error("read data not cleared at reset");

    // ********************************
    // pin checks per debug level
    // ********************************
    // level 0 leaves the companion to its own port logic
    chk_level0_comp: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ8]
        (debug_level == GPT_LVL0)
        |-> (comp_pin_o == companion_latch) && (comp_pin_oe == companion_direction_control))
        else $error("companion not plain at level 0");

    // split level: this port is plain unless the function byte is full
    chk_level3_main: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ7]
        (debug_level == GPT_LVL3) && (func_reg != GPT_FUNC_ALL)
        |-> (port_pin_o == latch_reg) && (port_pin_oe == dir_reg))
        else $error("port not plain at split level without full function byte");
    chk_level3_trace: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ7]
        (debug_level == GPT_LVL3) && (func_reg == GPT_FUNC_ALL)
        |-> (port_pin_o == trace_data_output) && (&port_pin_oe))
        else $error("split level with full function byte lacks trace data");

    // split level without a full byte: companion carries trace data on selected bits
    chk_comp_split_data: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ8]
        (debug_level == GPT_LVL3) && (func_reg != GPT_FUNC_ALL)
        |-> (((comp_pin_o ^ trace_data_output) & func_reg) == '0))
        else $error("companion lacks trace data at split level");

    // level 5: companion drives trace control on every selected bit
    chk_level5_comp: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ8]
        (debug_level == GPT_LVL5) |-> (((comp_pin_o ^ trace_control_output) & func_reg) == '0)
            && ((comp_pin_oe & func_reg) == func_reg))
        else $error("companion lacks trace control at level 5");

    // level 5: this port drives trace data on every selected bit
    chk_level5_bits: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ5]
        (debug_level == GPT_LVL5) |-> (((port_pin_o ^ trace_data_output) & func_reg) == '0))
        else $error("selected pins lack trace data at level 5");

    // a clear function bit keeps the pin on its latch at every level
    chk_plain_bits: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ5]
        ((port_pin_o ^ latch_reg) & ~func_reg) == '0)
        else $error("pin without function bit lost its latch value");

    // same for the companion, whose function bits are shared
    chk_comp_plain_bits: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ5]
        ((comp_pin_o ^ companion_latch) & ~func_reg) == '0)
        else $error("companion pin without function bit lost its latch value");

    // trace can add drive but never take it from an output pin
    chk_dir_drives: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ1]
        (port_pin_oe & dir_reg) == dir_reg)
        else $error("output pin not driven");

    // level 1 with a full function byte drives every companion pin
    chk_level1_comp_oe: assert property (@(posedge core_clk) disable iff (!rst_n)  // see [RQ8]
        (debug_level == GPT_LVL1) && (func_reg == GPT_FUNC_ALL) |-> (&comp_pin_oe))
        else $error("companion not driven at level 1");
endmodule // gpt_port
